// File: bench/t1_link_code_detector_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlcd_defs.svh"

module t1_link_code_detector_bench;
  logic       ref_clk;
  logic       arst_n;
  logic       ce;
  logic       t1_mode;
  logic [7:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic       cpu_wr;
  logic       cpu_rd;
  logic [7:0] cpu_rdata;
  logic       rx_link_vld;
  logic       rx_link_bit;
  logic       tx_link_req;
  logic       tx_link_bit;
  logic       irq;
  logic       b;
  logic [7:0] base;
  int         mismatches;
  int         checked;
  logic [5:0] codes [4] = '{6'h05, 6'h2A, 6'h11, 6'h00};
  int         need [4]  = '{1, 3, 5, 7};
  logic [7:0] regs [8]  = '{`TLCD_ADDR_FLAGS, `TLCD_ADDR_MASK, `TLCD_ADDR_CTRL, `TLCD_ADDR_RXCODE,
                            `TLCD_ADDR_TXDATA, `TLCD_ADDR_MATCH1, `TLCD_ADDR_MATCH2, 8'h10};
  logic [7:0] mv [2]    = '{8'h5A, 8'hC3};

  tlcd_link_code_ctrl DUT (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .ce          (ce),
    .t1_mode     (t1_mode),
    .cpu_addr    (cpu_addr),
    .cpu_wdata   (cpu_wdata),
    .cpu_wr      (cpu_wr),
    .cpu_rd      (cpu_rd),
    .cpu_rdata   (cpu_rdata),
    .rx_link_vld (rx_link_vld),
    .rx_link_bit (rx_link_bit),
    .tx_link_req (tx_link_req),
    .tx_link_bit (tx_link_bit),
    .irq         (irq)
  );

  tlcd_far_end far (
    .ref_clk     (ref_clk),
    .rx_link_vld (rx_link_vld),
    .rx_link_bit (rx_link_bit),
    .tx_link_req (tx_link_req),
    .tx_link_bit (tx_link_bit)
  );

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmpb(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : cmpb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_wr    <= 1'b1;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask : wr

  // Read data is registered, so sample one edge after the strobe is taken
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp, input string what);
    repeat (2) @(posedge ref_clk);
    cpu_rd   <= 1'b1;
    cpu_addr <= a;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    cmp8(what, exp & m, cpu_rdata & m);
  endtask : rchk

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge ref_clk);
    #1;
    cmpb("irq", exp, irq);
  endtask : irq_chk

  task automatic summarize();
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // Hang guard, far beyond the fewer than two thousand cycles the tests need
  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  initial begin
    {arst_n, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = '0;
    t1_mode = 1'b1;
    ce      = 1'b1;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    cmpb("tx idle level", 1'b1, tx_link_bit);
    wr(`TLCD_ADDR_FLAGS, 8'hFF);
    wr(`TLCD_ADDR_RXCODE, 8'hFF);
    foreach (regs[i]) rchk(regs[i], 8'hFF, 8'h00, "reset value");
    // A write taken while the clock enable is low must not land
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(`TLCD_ADDR_MASK, 8'h3F);
    ce <= 1'b1;
    rchk(`TLCD_ADDR_MASK, 8'hFF, 8'h00, "mask while frozen");
    // Filter select zero and enable set in one write
    wr(`TLCD_ADDR_CTRL, 8'h10);
    rchk(`TLCD_ADDR_RXCODE, 8'hFF, 8'h3F, "preset code");
    far.send_code(6'h05, 1);
    rchk(`TLCD_ADDR_FLAGS, 8'hFF, 8'h19, "event flags");
    rchk(`TLCD_ADDR_RXCODE, 8'hFF, 8'h05, "code");
    irq_chk(1'b0);
    wr(`TLCD_ADDR_MASK, 8'h01);
    irq_chk(1'b1);
    wr(`TLCD_ADDR_FLAGS, 8'h01);
    irq_chk(1'b0);
    rchk(`TLCD_ADDR_FLAGS, 8'hFF, 8'h18, "sticky flags");
    wr(`TLCD_ADDR_MASK, 8'h00);
    // Every filter setting: one pattern short, then the last one
    for (int f = 0; f < 4; f++) begin
      base = 8'h10 | 8'(f << 1);
      wr(`TLCD_ADDR_CTRL, base);
      wr(`TLCD_ADDR_CTRL, base | 8'h08);
      rchk(`TLCD_ADDR_RXCODE, 8'hFF, 8'h3F, "code after reset");
      far.send_code(codes[f], need[f] - 1);
      rchk(`TLCD_ADDR_RXCODE, 8'hFF, 8'h3F, "code short of count");
      far.send_code(codes[f], 1);
      rchk(`TLCD_ADDR_RXCODE, 8'hFF, {2'b00, codes[f]}, "filtered code");
      wr(`TLCD_ADDR_CTRL, base | 8'h08);
      rchk(`TLCD_ADDR_RXCODE, 8'hFF, {2'b00, codes[f]}, "code with reset held");
    end
    // Outside T1, then disabled: plain byte view and no code events
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      t1_mode <= (m == 1);
      wr(`TLCD_ADDR_CTRL, (m == 1) ? 8'h00 : 8'h10);
      wr(`TLCD_ADDR_FLAGS, 8'h3F);
      far.send_code(6'h0C, 2);
      rchk(`TLCD_ADDR_FLAGS, 8'h01, 8'h00, "no code change");
      rchk(`TLCD_ADDR_RXCODE, 8'hFF, far.last_byte, "byte view");
    end
    // Match values on aligned bytes, with a slow far end
    wr(`TLCD_ADDR_MATCH1, mv[0]);
    wr(`TLCD_ADDR_MATCH2, mv[1]);
    far.gap = 2;
    far.pad();
    for (int i = 0; i < 3; i++) begin
      wr(`TLCD_ADDR_FLAGS, 8'h3F);
      far.send_byte((i < 2) ? mv[i] : 8'h3C);
      rchk(`TLCD_ADDR_FLAGS, 8'h0A, (i < 2) ? 8'h0A : 8'h08, "match and full");
    end
    far.gap = 0;
    // Abort on exactly eight ones, clear on exactly thirty bits after it
    wr(`TLCD_ADDR_FLAGS, 8'h3F);
    far.send_bit(1'b0);
    repeat (7) far.send_bit(1'b1);
    rchk(`TLCD_ADDR_FLAGS, 8'h10, 8'h00, "abort early");
    far.send_bit(1'b1);
    rchk(`TLCD_ADDR_FLAGS, 8'h10, 8'h10, "abort");
    wr(`TLCD_ADDR_FLAGS, 8'h3F);
    repeat (29) far.send_bit(1'b0);
    rchk(`TLCD_ADDR_FLAGS, 8'h20, 8'h00, "clear early");
    far.send_bit(1'b0);
    rchk(`TLCD_ADDR_FLAGS, 8'h20, 8'h20, "clear");
    // Transmit code frames repeat while send stays set
    wr(`TLCD_ADDR_TXDATA, 8'h2B);
    wr(`TLCD_ADDR_CTRL, 8'h01);
    for (int k = 0; k < 32; k++) begin
      far.get_bit(b);
      cmpb("code slot", far.pat(6'h2B, k % 16), b);
    end
    // Plain byte goes out least significant bit first, then idle ones
    base = 8'hA5;
    wr(`TLCD_ADDR_CTRL, 8'h00);
    wr(`TLCD_ADDR_FLAGS, 8'h3F);
    wr(`TLCD_ADDR_TXDATA, base);
    for (int k = 0; k < 24; k++) begin
      far.get_bit(b);
      cmpb("data slot", (k < 8) ? base[k] : 1'b1, b);
    end
    rchk(`TLCD_ADDR_FLAGS, 8'h04, 8'h04, "tx empty");
    // Send bit outside T1 must leave the line idle
    @(posedge ref_clk);
    t1_mode <= 1'b0;
    wr(`TLCD_ADDR_CTRL, 8'h01);
    for (int k = 0; k < 16; k++) begin
      far.get_bit(b);
      cmpb("slot outside T1", 1'b1, b);
    end
    summarize();
  end
endmodule : t1_link_code_detector_bench

`default_nettype wire

// File: bench/tlcd_far_end.sv
`timescale 1ns/10ps
`default_nettype none

// Remote T1 end: drives received link bits and pulls transmit slots
module tlcd_far_end (
  input  wire logic ref_clk,
  output logic      rx_link_vld,
  output logic      rx_link_bit,
  output logic      tx_link_req,
  input  wire logic tx_link_bit
);
  logic [7:0] shift_r;
  logic [7:0] last_byte;
  int         nbits;
  int         gap;

  // Quiet link at time zero
  initial begin
    rx_link_vld = 1'b0;
    rx_link_bit = 1'b1;
    tx_link_req = 1'b0;
    shift_r     = 8'h00;
    last_byte   = 8'h00;
    nbits       = 0;
    gap         = 0;
  end

  // Code frame: eight ones, zero, six code bits, zero
  function automatic logic pat(input logic [5:0] c, input int k);
    if (k < 8)
      return 1'b1;
    if (k == 8 || k == 15)
      return 1'b0;
    return c[k - 9];
  endfunction : pat

  // One bit; the line toggles after release so stale data never looks valid
  task automatic send_bit(input logic b);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    rx_link_vld <= 1'b1;
    rx_link_bit <= b;
    shift_r = {b, shift_r[7:1]};
    nbits++;
    if (nbits % 8 == 0)
      last_byte = shift_r;
    @(posedge ref_clk);
    rx_link_vld <= 1'b0;
    rx_link_bit <= ~b;
  endtask : send_bit

  task automatic send_code(input logic [5:0] c, input int n);
    for (int i = 0; i < n * 16; i++)
      send_bit(pat(c, i % 16));
  endtask : send_code

  // Bytes go least significant bit first
  task automatic send_byte(input logic [7:0] v);
    for (int k = 0; k < 8; k++)
      send_bit(v[k]);
  endtask : send_byte

  // Zeros keep padding from looking like an abort
  task automatic pad();
    while (nbits % 8 != 0)
      send_bit(1'b0);
  endtask : pad

  task automatic get_bit(output logic b);
    @(posedge ref_clk);
    tx_link_req <= 1'b1;
    @(posedge ref_clk);
    tx_link_req <= 1'b0;
    @(posedge ref_clk);
    #1;
    b = tx_link_bit;
  endtask : get_bit
endmodule : tlcd_far_end

`default_nettype wire

// File: pkg/tlcd_defs.svh
`ifndef TLCD_DEFS_SVH
`define TLCD_DEFS_SVH

// Register offsets on the parallel port
`define TLCD_ADDR_FLAGS   8'h24
`define TLCD_ADDR_MASK    8'h25
`define TLCD_ADDR_CTRL    8'h37
`define TLCD_ADDR_RXCODE  8'hC0
`define TLCD_ADDR_TXDATA  8'hE0
`define TLCD_ADDR_MATCH1  8'hE1
`define TLCD_ADDR_MATCH2  8'hE2

// Control register fields
`define TLCD_CTRL_SEND    0
`define TLCD_CTRL_FILT    1
`define TLCD_CTRL_RST     3
`define TLCD_CTRL_RXEN    4
`define TLCD_CTRL_W       5

// Event bit positions, shared by flags and mask
`define TLCD_EV_CODE      0
`define TLCD_EV_MATCH     1
`define TLCD_EV_EMPTY     2
`define TLCD_EV_FULL      3
`define TLCD_EV_ABORT     4
`define TLCD_EV_CLEAR     5
`define TLCD_EV_W         6

// Reset values and presets
`define TLCD_REG_RESET    8'h00
`define TLCD_CODE_PRESET  6'h3F
`define TLCD_IDLE_BYTE    8'hFF

// Filter sightings per select value
`define TLCD_FILT_NONE    3'h1
`define TLCD_FILT_3       3'h3
`define TLCD_FILT_5       3'h5
`define TLCD_FILT_7       3'h7

// Link timing in bits
`define TLCD_ABORT_ONES   4'h8
`define TLCD_CLEAR_BITS   5'h1E
`define TLCD_FLAG_ONES    4'h8
`define TLCD_CODE_LAST    4'hF
`define TLCD_BYTE_LAST    4'h7
`define TLCD_GAP_LAST     5'h0F

`endif

// File: pkg/tlcd_pkg.sv
package tlcd_pkg;

  // What the transmitter is putting on the link
  typedef enum logic [1:0] {
    TLCD_TX_IDLE,
    TLCD_TX_DATA,
    TLCD_TX_CODE
  } tlcd_tx_type;

endpackage : tlcd_pkg

// File: rtl/tlcd_code_det.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlcd_defs.svh"

module tlcd_code_det
  import tlcd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       bit_vld,
  input  wire logic       bit_in,
  input  wire logic       det_on,
  input  wire logic       det_clr,
  input  wire logic [1:0] filt_sel,
  output logic      [5:0] code_q,
  output logic            change_q
);

  logic [15:0] sh_r, sh_nxt, sh_new;
  logic [5:0]  cand_r, cand_nxt, cand;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [4:0]  gap_r, gap_nxt;
  logic [5:0]  code_nxt;
  logic        chg_nxt;
  logic        hit;

  // Sightings needed before a code counts as valid
  function automatic logic [2:0] need_of(input logic [1:0] sel);
    case (sel)
      2'h0:    need_of = `TLCD_FILT_NONE;
      2'h1:    need_of = `TLCD_FILT_3;
      2'h2:    need_of = `TLCD_FILT_5;
      default: need_of = `TLCD_FILT_7;
    endcase
  endfunction : need_of

  // Pattern is eight ones, a zero, six code bits first-bit-zero, a zero
  always_comb begin
    sh_new   = {sh_r[14:0], bit_in};
    cand     = {sh_new[1], sh_new[2], sh_new[3], sh_new[4], sh_new[5], sh_new[6]};
    hit      = (sh_new[15:8] == `TLCD_IDLE_BYTE) && !sh_new[7] && !sh_new[0];
    sh_nxt   = sh_r;
    cand_nxt = cand_r;
    cnt_nxt  = cnt_r;
    gap_nxt  = gap_r;
    code_nxt = code_q;
    chg_nxt  = 1'b0;
    if (det_clr || !det_on) begin
      sh_nxt   = 16'h0000;
      cnt_nxt  = 3'h0;
      gap_nxt  = 5'h00;
      code_nxt = `TLCD_CODE_PRESET;
    end else if (bit_vld) begin
      sh_nxt = sh_new;
      if (hit) begin
        gap_nxt  = 5'h00;
        cand_nxt = cand;
        // Count identical back-to-back patterns, saturating
        if (cand == cand_r && cnt_r != 3'h0)
          cnt_nxt = (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;
        else
          cnt_nxt = 3'h1;
        if (cnt_nxt >= need_of(filt_sel) && cand != code_q) begin
          code_nxt = cand;
          chg_nxt  = 1'b1;
        end
      end else begin
        // A missed pattern slot is an error and restarts the filter
        gap_nxt = (gap_r == `TLCD_GAP_LAST) ? gap_r : gap_r + 5'h01;
        if (gap_r == `TLCD_GAP_LAST)
          cnt_nxt = 3'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r     <= 16'h0000;
      cand_r   <= 6'h00;
      cnt_r    <= 3'h0;
      gap_r    <= 5'h00;
      code_q   <= `TLCD_CODE_PRESET;
      change_q <= 1'b0;
    end else if (ce) begin
      sh_r     <= sh_nxt;
      cand_r   <= cand_nxt;
      cnt_r    <= cnt_nxt;
      gap_r    <= gap_nxt;
      code_q   <= code_nxt;
      change_q <= chg_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence clr_edge_s;
    ce && det_clr;
  endsequence

  det_preset_a:
    assert property (clr_edge_s |=> code_q == `TLCD_CODE_PRESET && cnt_r == 3'h0)
      else $error("detector not preset by reset edge");

  filt_count_a:
    assert property ($rose(change_q) |-> cnt_r >= need_of($past(filt_sel)))
      else $error("code accepted before filter count");

endmodule : tlcd_code_det
`default_nettype wire

// File: rtl/tlcd_link_code_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "tlcd_defs.svh"

// How it works
// - Receive code detection runs only when enabled
// - Code field presets to all ones
// - New valid code sets code change flag
// - Filter select picks 1, 3, 5, 7 sightings
// - Reset bit rising edge clears the detector
// - Code sits in receive register bits 5:0
// - Send bit transmits six-bit transmit code
// - Code starts at once, repeats while set
// - Code logic works only in T1 mode
// - Receive byte matching either value sets flag
// - Transmit empty and receive full set flags
// - Eight consecutive ones set abort flag
// - Thirty bits without abort set clear flag
// - Mask bits gate interrupt, reset to zero
module tlcd_link_code_ctrl
  import tlcd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       t1_mode,
  input  wire logic [7:0] cpu_addr,
  input  wire logic [7:0] cpu_wdata,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  output logic      [7:0] cpu_rdata,
  input  wire logic       rx_link_vld,
  input  wire logic       rx_link_bit,
  input  wire logic       tx_link_req,
  output logic            tx_link_bit,
  output logic            irq
);

  logic [`TLCD_CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [`TLCD_EV_W-1:0]   flags_r, flags_nxt, mask_r, mask_nxt, ev;
  logic [7:0]              txd_r, txd_nxt, m1_r, m1_nxt, m2_r, m2_nxt;
  logic [7:0]              rdata_nxt;
  logic                    pend_r, pend_nxt, rst_prev_r, irq_nxt;
  logic                    code_on, want_code, det_clr, det_chg, tx_load;
  logic [5:0]              det_code;
  logic [3:0]              ones_r, ones_nxt, txcnt_r, txcnt_nxt, idx, last;
  logic [4:0]              nab_r, nab_nxt;
  logic [7:0]              rxsh_r, rxsh_nxt, rxbyte_r, rxbyte_nxt, txh_r, txh_nxt, hold, rx_new;
  logic [2:0]              rxcnt_r, rxcnt_nxt;
  logic                    tx_bit_nxt, abort_hit;
  tlcd_tx_type             st_r, st_nxt, st;

  // Bit k of the repeating code pattern: flag ones, zero, code, zero
  function automatic logic pat_bit(input logic [3:0] k, input logic [5:0] code);
    logic [3:0] j;
    j = k - 4'h9;
    if (k < `TLCD_FLAG_ONES)
      pat_bit = 1'b1;
    else if (k == `TLCD_FLAG_ONES || k == `TLCD_CODE_LAST)
      pat_bit = 1'b0;
    else
      pat_bit = code[j[2:0]];
  endfunction : pat_bit

  assign code_on   = ctrl_r[`TLCD_CTRL_RXEN] & t1_mode;
  assign want_code = ctrl_r[`TLCD_CTRL_SEND] & t1_mode;
  // Only a rising edge resets, so a held bit does not keep the detector dead
  assign det_clr   = ctrl_r[`TLCD_CTRL_RST] & ~rst_prev_r;

  tlcd_code_det u_det (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .bit_vld  (rx_link_vld),
    .bit_in   (rx_link_bit),
    .det_on   (code_on),
    .det_clr  (det_clr),
    .filt_sel (ctrl_r[`TLCD_CTRL_FILT+1:`TLCD_CTRL_FILT]),
    .code_q   (det_code),
    .change_q (det_chg)
  );

  // Link side: receive byte, ones runs, transmit sequencing
  always_comb begin
    ones_nxt   = ones_r;
    nab_nxt    = nab_r;
    rxsh_nxt   = rxsh_r;
    rxcnt_nxt  = rxcnt_r;
    rxbyte_nxt = rxbyte_r;
    st_nxt     = st_r;
    txcnt_nxt  = txcnt_r;
    txh_nxt    = txh_r;
    tx_bit_nxt = tx_link_bit;
    ev         = '0;
    tx_load    = 1'b0;
    st         = st_r;
    idx        = txcnt_r;
    hold       = txh_r;
    last       = `TLCD_BYTE_LAST;
    rx_new     = {rx_link_bit, rxsh_r[7:1]};
    abort_hit  = rx_link_vld && rx_link_bit && ones_r == `TLCD_ABORT_ONES - 4'h1;
    ev[`TLCD_EV_CODE] = det_chg;
    if (rx_link_vld) begin
      ones_nxt = !rx_link_bit ? 4'h0 : (ones_r == `TLCD_ABORT_ONES) ? ones_r : ones_r + 4'h1;
      ev[`TLCD_EV_ABORT] = abort_hit;
      if (abort_hit)
        nab_nxt = 5'h00;
      else if (nab_r != `TLCD_CLEAR_BITS)
        nab_nxt = nab_r + 5'h01;
      ev[`TLCD_EV_CLEAR] = !abort_hit && nab_r == `TLCD_CLEAR_BITS - 5'h01;
      rxsh_nxt  = rx_new;
      rxcnt_nxt = rxcnt_r + 3'h1;
      if (rxcnt_r == `TLCD_BYTE_LAST) begin
        rxbyte_nxt = rx_new;
        ev[`TLCD_EV_FULL]  = 1'b1;
        ev[`TLCD_EV_MATCH] = (rx_new == m1_r) || (rx_new == m2_r);
      end
    end
    if (tx_link_req) begin
      // Switching into or out of code mode cuts the unit short at once
      if (txcnt_r == 4'h0 || want_code != (st_r == TLCD_TX_CODE)) begin
        idx = 4'h0;
        if (want_code) begin
          st   = TLCD_TX_CODE;
          hold = txd_r;
        end else if (pend_r) begin
          st      = TLCD_TX_DATA;
          hold    = txd_r;
          tx_load = 1'b1;
        end else begin
          st   = TLCD_TX_IDLE;
          hold = `TLCD_IDLE_BYTE;
        end
      end
      case (st)
        TLCD_TX_CODE: begin
          tx_bit_nxt = pat_bit(idx, hold[5:0]);
          last       = `TLCD_CODE_LAST;
        end
        default: tx_bit_nxt = hold[idx[2:0]];
      endcase
      ev[`TLCD_EV_EMPTY] = tx_load;
      txcnt_nxt = (idx == last) ? 4'h0 : idx + 4'h1;
      st_nxt    = st;
      txh_nxt   = hold;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_r      <= 4'h0;
      nab_r       <= 5'h00;
      rxsh_r      <= `TLCD_REG_RESET;
      rxcnt_r     <= 3'h0;
      rxbyte_r    <= `TLCD_REG_RESET;
      st_r        <= TLCD_TX_IDLE;
      txcnt_r     <= 4'h0;
      txh_r       <= `TLCD_IDLE_BYTE;
      tx_link_bit <= 1'b1;
    end else if (ce) begin
      ones_r      <= ones_nxt;
      nab_r       <= nab_nxt;
      rxsh_r      <= rxsh_nxt;
      rxcnt_r     <= rxcnt_nxt;
      rxbyte_r    <= rxbyte_nxt;
      st_r        <= st_nxt;
      txcnt_r     <= txcnt_nxt;
      txh_r       <= txh_nxt;
      tx_link_bit <= tx_bit_nxt;
    end
  end

  // Register port: writes, acknowledge, read mux, sticky flags
  always_comb begin
    ctrl_nxt  = ctrl_r;
    mask_nxt  = mask_r;
    txd_nxt   = txd_r;
    m1_nxt    = m1_r;
    m2_nxt    = m2_r;
    flags_nxt = flags_r;
    rdata_nxt = cpu_rdata;
    pend_nxt  = pend_r & ~tx_load;
    irq_nxt   = |(flags_r & mask_r);
    if (cpu_wr) begin
      case (cpu_addr)
        `TLCD_ADDR_FLAGS:  flags_nxt = flags_r & ~cpu_wdata[`TLCD_EV_W-1:0];
        `TLCD_ADDR_MASK:   mask_nxt  = cpu_wdata[`TLCD_EV_W-1:0];
        `TLCD_ADDR_CTRL:   ctrl_nxt  = cpu_wdata[`TLCD_CTRL_W-1:0];
        `TLCD_ADDR_TXDATA: begin
          txd_nxt  = cpu_wdata;
          pend_nxt = 1'b1;
        end
        `TLCD_ADDR_MATCH1: m1_nxt = cpu_wdata;
        `TLCD_ADDR_MATCH2: m2_nxt = cpu_wdata;
        default: ;
      endcase
    end
    // Events are ORed last so a set in the acknowledge cycle survives
    flags_nxt = flags_nxt | ev;
    if (cpu_rd) begin
      case (cpu_addr)
        `TLCD_ADDR_FLAGS:  rdata_nxt = {2'h0, flags_r};
        `TLCD_ADDR_MASK:   rdata_nxt = {2'h0, mask_r};
        `TLCD_ADDR_CTRL:   rdata_nxt = {3'h0, ctrl_r};
        `TLCD_ADDR_RXCODE: rdata_nxt = code_on ? {2'h0, det_code} : rxbyte_r;
        `TLCD_ADDR_TXDATA: rdata_nxt = txd_r;
        `TLCD_ADDR_MATCH1: rdata_nxt = m1_r;
        `TLCD_ADDR_MATCH2: rdata_nxt = m2_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r     <= '0;
      mask_r     <= '0;
      flags_r    <= '0;
      txd_r      <= `TLCD_REG_RESET;
      m1_r       <= `TLCD_REG_RESET;
      m2_r       <= `TLCD_REG_RESET;
      pend_r     <= 1'b0;
      rst_prev_r <= 1'b0;
      irq        <= 1'b0;
      cpu_rdata  <= `TLCD_REG_RESET;
    end else if (ce) begin
      ctrl_r     <= ctrl_nxt;
      mask_r     <= mask_nxt;
      flags_r    <= flags_nxt;
      txd_r      <= txd_nxt;
      m1_r       <= m1_nxt;
      m2_r       <= m2_nxt;
      pend_r     <= pend_nxt;
      rst_prev_r <= ctrl_r[`TLCD_CTRL_RST];
      irq        <= irq_nxt;
      cpu_rdata  <= rdata_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence ack_code_s;
    ce && cpu_wr && cpu_addr == `TLCD_ADDR_FLAGS && cpu_wdata[`TLCD_EV_CODE];
  endsequence

  irq_gate_a:
    assert property (ce |=> irq == $past(|(flags_r & mask_r)))
      else $error("irq does not follow masked flags");

  flag_sticky_a:
    assert property (ce && flags_r[`TLCD_EV_CODE]
                     && !(cpu_wr && cpu_addr == `TLCD_ADDR_FLAGS && cpu_wdata[`TLCD_EV_CODE])
                     |=> flags_r[`TLCD_EV_CODE])
      else $error("code change flag dropped without acknowledge");

  // An acknowledge with no new event in the same cycle must clear the flag
  flag_ack_a:
    assert property (ack_code_s ##0 !det_chg |=> !flags_r[`TLCD_EV_CODE])
      else $error("code change flag not acknowledged");

  code_flag_a:
    assert property (ce && det_chg |=> flags_r[`TLCD_EV_CODE])
      else $error("code change not flagged");

  abort_flag_a:
    assert property (ce && rx_link_vld && rx_link_bit && ones_r == 4'h7 |=> flags_r[`TLCD_EV_ABORT])
      else $error("eight ones not flagged as abort");

  clear_flag_a:
    assert property (ce && rx_link_vld && !abort_hit && nab_r == 5'h1D |=> flags_r[`TLCD_EV_CLEAR])
      else $error("thirty bits without abort not flagged");

  match_flag_a:
    assert property (ce && rx_link_vld && rxcnt_r == 3'h7 && rx_new == m1_r |=> flags_r[`TLCD_EV_MATCH])
      else $error("match value not flagged");

  rx_code_read_a:
    assert property (ce && cpu_rd && cpu_addr == `TLCD_ADDR_RXCODE && code_on
                     |=> cpu_rdata == {2'h0, $past(det_code)})
      else $error("receive register does not show code");

  tx_flag_ones_a:
    assert property (ce && tx_link_req && want_code && st_r == TLCD_TX_CODE && txcnt_r < 4'h8
                     |=> tx_link_bit)
      else $error("code pattern flag bit not one");

  tx_t1_only_a:
    assert property (ce && tx_link_req && !t1_mode |=> st_r != TLCD_TX_CODE)
      else $error("code sent outside T1 mode");

endmodule : tlcd_link_code_ctrl
`default_nettype wire
